/* core/ufd_pkg.sv */
/*
  constants for the uart queue-depth and infrared select logic.
  assumes one 10 MHz clock and synchronous user-side inputs.
*/
// Contract
// - strap low: queues limited to sixteen entries
// - strap high: queues hold 128 entries
// - software reads live strap level anytime
// - bit5 write with divisor latch forces 128
// - enhanced mode forces 128 entry queues
// - modem bit6 in enhanced: infrared transmit
// - infrared enabled: receiver decodes infrared input
// - shared pin: second irq or clock-run
// - primary irq carries both functions by default
package ufd_pkg;
  localparam int CHANNELS = 2;
  localparam int DATA_W = 8;
  localparam int QUEUE_DEPTH = 128;
  localparam int LEVEL_W = 8;
  localparam logic [7:0] LEGACY_DEPTH = 8'h10;
  localparam logic [7:0] EXT_DEPTH = 8'h80;
  localparam int QCR_EXT_BIT = 5;
  localparam int LFR_LATCH_BIT = 7;
  localparam int MLCR_IRDA_BIT = 6;
  localparam logic [3:0] BIT_TICKS_LAST = 4'hf;
  localparam logic [3:0] IRDA_PULSE_TICKS = 4'h3;
  localparam logic [3:0] TX_CNT_RESET = 4'hf;
  localparam logic EXT_LATCH_RESET = 1'b0;
  typedef enum logic [0:0] {
    UFD_RX_IDLE = 1'b0,
    UFD_RX_PULSE = 1'b1
  } ufd_rx_state_t;
endpackage

/* core/ufd_fifo.sv */
/*
  synchronous fifo with a registered output stage and a run-time cap.
  assumes depth is a power of two and limit never exceeds depth.
*/
`timescale 1ns/100ps
`default_nettype none
module ufd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [$clog2(DEPTH+1)-1:0] limit,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] cnt, next_cnt, next_level;
  logic next_in_ready, next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push, load;

  // ready is recomputed from the next fill, so a lowered cap stalls the source from the next clock edge
  always_comb
  begin
    push = in_valid && in_ready;
    load = (cnt != '0) && (!out_valid || out_ready);
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = load ? rd_ptr + AW'(1) : rd_ptr;
    next_cnt = cnt + CW'(push) - CW'(load);
    next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    next_out_data = load ? mem[rd_ptr] : out_data;
    next_level = next_cnt + CW'(next_out_valid);
    next_in_ready = next_level < limit;
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
      level <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      cnt <= next_cnt;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      level <= next_level;
      in_ready <= next_in_ready;
    end
  end

  // storage has no reset; the output stage hides stale words
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_level_cap: assert property (level > limit |=> !in_ready)
    else $error("fifo accepts past its cap");
  a_cap_holds: assert property (in_ready |-> level < limit)
    else $error("ready while level at cap");
endmodule
`default_nettype wire

/* core/ufd_top.sv */
/*
  queue-depth selection, infrared pin switching and host irq pin use for
  two uart channels, with one transmit queue per channel.
  assumes register bits arrive as decoded levels and write pulses, and
  that baud16_tick is a one-cycle enable at sixteen times the bit rate.
*/
`timescale 1ns/100ps
`default_nettype none
module ufd_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fifo_depth_strap,
  output logic strap_level,
  input wire logic [1:0] queue_control_wr,
  input wire logic [1:0][7:0] queue_control_reg,
  input wire logic [1:0][7:0] line_format_reg,
  input wire logic [1:0][7:0] modem_line_control_reg,
  input wire logic [1:0] enhanced_mode,
  output logic [1:0] depth_is_128,
  input wire logic [1:0] tx_in_valid,
  output logic [1:0] tx_in_ready,
  input wire logic [1:0][7:0] tx_in_data,
  output logic [1:0] tx_out_valid,
  input wire logic [1:0] tx_out_ready,
  output logic [1:0][7:0] tx_out_data,
  output logic [1:0][7:0] tx_level,
  input wire logic baud16_tick,
  input wire logic [1:0] tx_serial,
  input wire logic [1:0] tx_bit_start,
  output logic [1:0] serial_tx_pin,
  input wire logic [1:0] serial_rx_pin,
  output logic [1:0] rx_serial,
  input wire logic func0_irq,
  input wire logic func1_irq,
  input wire logic func1_to_secondary,
  input wire logic mini_pci_mode,
  input wire logic clkrun_request,
  output logic primary_irq_line_o,
  output logic primary_irq_line_oe,
  output logic secondary_irq_line_o,
  output logic secondary_irq_line_oe,
  input wire logic secondary_irq_line_i
);
  logic strap_meta, next_strap_meta, next_strap_level;
  logic [1:0] ext_latch, next_ext_latch, next_depth;
  logic [1:0] irda_on;
  logic [1:0][3:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  ufd_pkg::ufd_rx_state_t [1:0] rx_state, next_rx_state;
  logic [1:0] next_tx_pin, next_rx_serial;
  logic next_pri_oe, next_sec_oe, sec_level;

  // strap sync and depth choice; first stage is read only by the second
  always_comb
  begin
    next_strap_meta = fifo_depth_strap;
    next_strap_level = strap_meta;
    for (int c = 0; c < ufd_pkg::CHANNELS; c++)
    begin
      next_ext_latch[c] = ext_latch[c];
      if (queue_control_wr[c] && line_format_reg[c][ufd_pkg::LFR_LATCH_BIT])
      begin
        next_ext_latch[c] = queue_control_reg[c][ufd_pkg::QCR_EXT_BIT];
      end
      // strap low alone leaves the legacy cap in force
      next_depth[c] = strap_level || ext_latch[c] || enhanced_mode[c];
    end
  end

  // depth registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_meta <= 1'b0;
      strap_level <= 1'b0;
      ext_latch <= {2{ufd_pkg::EXT_LATCH_RESET}};
      depth_is_128 <= 2'h0;
    end
    else
    begin
      strap_meta <= next_strap_meta;
      strap_level <= next_strap_level;
      ext_latch <= next_ext_latch;
      depth_is_128 <= next_depth;
    end
  end

  // one transmit queue per channel, capped by the selected depth
  for (genvar g = 0; g < ufd_pkg::CHANNELS; g++)
  begin : g_queue
    ufd_fifo #(
      .WIDTH(ufd_pkg::DATA_W),
      .DEPTH(ufd_pkg::QUEUE_DEPTH)
    ) u_queue (
      .clk(clk),
      .rst_n(rst_n),
      .limit(depth_is_128[g] ? ufd_pkg::EXT_DEPTH : ufd_pkg::LEGACY_DEPTH),
      .in_valid(tx_in_valid[g]),
      .in_ready(tx_in_ready[g]),
      .in_data(tx_in_data[g]),
      .out_valid(tx_out_valid[g]),
      .out_ready(tx_out_ready[g]),
      .out_data(tx_out_data[g]),
      .level(tx_level[g])
    );
  end

  // infrared encode and decode; a pulse is three of sixteen ticks
  always_comb
  begin
    for (int c = 0; c < ufd_pkg::CHANNELS; c++)
    begin
      irda_on[c] = enhanced_mode[c] && modem_line_control_reg[c][ufd_pkg::MLCR_IRDA_BIT];
      next_tx_cnt[c] = tx_cnt[c];
      if (tx_bit_start[c])
      begin
        next_tx_cnt[c] = 4'h0;
      end
      else if (baud16_tick && tx_cnt[c] != ufd_pkg::BIT_TICKS_LAST)
      begin
        next_tx_cnt[c] = tx_cnt[c] + 4'h1;
      end
      // a zero bit is sent as a short high pulse, a one as no light
      next_tx_pin[c] = irda_on[c] ? (!tx_serial[c] && (next_tx_cnt[c] < ufd_pkg::IRDA_PULSE_TICKS))
                                  : tx_serial[c];
      next_rx_state[c] = rx_state[c];
      next_rx_cnt[c] = rx_cnt[c];
      case (rx_state[c])
        ufd_pkg::UFD_RX_IDLE:
        begin
          if (serial_rx_pin[c])
          begin
            next_rx_state[c] = ufd_pkg::UFD_RX_PULSE;
            next_rx_cnt[c] = 4'h0;
          end
        end
        ufd_pkg::UFD_RX_PULSE:
        begin
          // stretch the short pulse over one whole bit time
          if (baud16_tick)
          begin
            next_rx_cnt[c] = rx_cnt[c] + 4'h1;
            if (rx_cnt[c] == ufd_pkg::BIT_TICKS_LAST && !serial_rx_pin[c])
            begin
              next_rx_state[c] = ufd_pkg::UFD_RX_IDLE;
            end
          end
        end
        default:
        begin
          next_rx_state[c] = ufd_pkg::UFD_RX_IDLE;
        end
      endcase
      next_rx_serial[c] = irda_on[c] ? (next_rx_state[c] == ufd_pkg::UFD_RX_IDLE)
                                     : serial_rx_pin[c];
    end
  end

  // line coding registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_cnt <= {2{ufd_pkg::TX_CNT_RESET}};
      rx_cnt <= '0;
      rx_state[0] <= ufd_pkg::UFD_RX_IDLE;
      rx_state[1] <= ufd_pkg::UFD_RX_IDLE;
      serial_tx_pin <= 2'h3;
      rx_serial <= 2'h3;
    end
    else
    begin
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      rx_state <= next_rx_state;
      serial_tx_pin <= next_tx_pin;
      rx_serial <= next_rx_serial;
    end
  end

  // open-drain pins only ever pull low; the shared pin changes role with bus mode
  always_comb
  begin
    sec_level = secondary_irq_line_i;
    next_pri_oe = func0_irq || (func1_irq && (mini_pci_mode || !func1_to_secondary));
    // clock-run is held low only while the host tries to stop the clock
    next_sec_oe = mini_pci_mode ? (clkrun_request && sec_level)
                                : (func1_irq && func1_to_secondary);
  end

  // irq pin registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_irq_line_oe <= 1'b0;
      secondary_irq_line_oe <= 1'b0;
      primary_irq_line_o <= 1'b0;
      secondary_irq_line_o <= 1'b0;
    end
    else
    begin
      primary_irq_line_oe <= next_pri_oe;
      secondary_irq_line_oe <= next_sec_oe;
      primary_irq_line_o <= 1'b0;
      secondary_irq_line_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_strap_live_read: assert property (##2 strap_level == $past(fifo_depth_strap, 2))
    else $error("strap level not two cycles behind pin");
  a_strap_two_flops: assert property ($rose(fifo_depth_strap) ##1 fifo_depth_strap |-> !strap_level)
    else $error("strap used without synchronising");
  a_depth_legacy: assert property (!strap_level && !ext_latch[0] && !enhanced_mode[0] |=> !depth_is_128[0])
    else $error("legacy depth not kept");
  a_depth_strap_high: assert property (strap_level |=> depth_is_128 == 2'h3)
    else $error("strap high without deep queues");
  a_depth_sw_force: assert property (queue_control_wr[0]
    && queue_control_reg[0][ufd_pkg::QCR_EXT_BIT]
    && line_format_reg[0][ufd_pkg::LFR_LATCH_BIT] |-> ##2 depth_is_128[0])
    else $error("software force ignored");
  a_depth_enhanced: assert property (enhanced_mode[0] |=> depth_is_128[0])
    else $error("enhanced mode without deep queues");
  a_tx_normal_path: assert property (!irda_on[0] |=> serial_tx_pin[0] == $past(tx_serial[0]))
    else $error("normal transmit not passed through");
  a_tx_irda_dark: assert property (irda_on[0] && tx_serial[0] |=> !serial_tx_pin[0])
    else $error("infrared sends light on a one bit");
  a_rx_irda_pulse: assert property (irda_on[0] && serial_rx_pin[0] |=> !rx_serial[0])
    else $error("infrared pulse not decoded as zero");
  a_irq_primary: assert property (func0_irq || (func1_irq && !func1_to_secondary) |=> primary_irq_line_oe)
    else $error("primary irq not driven");
  a_pin_clkrun: assert property (mini_pci_mode |=> secondary_irq_line_oe == $past(clkrun_request && secondary_irq_line_i))
    else $error("shared pin role wrong in mini mode");

  c_deep_fill: cover property (depth_is_128[0] && tx_level[0] > 8'h10);
  c_legacy_full: cover property (!depth_is_128[1] && !tx_in_ready[1] && tx_in_valid[1]);
  c_irda_rx: cover property (irda_on[0] && !rx_serial[0] ##1 rx_serial[0]);
  c_clkrun_hold: cover property (mini_pci_mode && secondary_irq_line_oe);
endmodule
`default_nettype wire

/* sim/ufd_peer.sv */
/*
  far-side model: serial peer or infrared transceiver driving the rx pins.
  assumes the bench asks for one zero bit at a time, baud ticks held high.
*/
`timescale 1ns/100ps
`default_nettype none
module ufd_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] irda,
  input wire logic [1:0] send_zero,
  output logic [1:0] serial_rx_pin
);
  logic [1:0][1:0] left;
  // pulse length counter, a few cycles is short of a full bit on purpose
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (send_zero[c])
          left[c] <= 2'h3;
        else if (left[c] != 2'h0)
          left[c] <= left[c] - 2'h1;
      end
    end
  end
  // infrared: short high pulse per zero bit; normal line idles high
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      serial_rx_pin[c] = irda[c] ? (left[c] != 2'h0) : ~send_zero[c];
    end
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
/*
  self-checking bench for the queue-depth, infrared and irq pin logic.
  assumes ufd_top with its ufd_fifo and ufd_pkg, and ufd_peer, are compiled alongside; no other files.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_n, strap, strap_level, tick, f0, f1, route, mini, clkrun, host_val;
  logic p_o, p_oe, s_o, s_oe;
  logic [1:0] qc_wr, enh, depth, in_v, in_r, out_v, out_r, tx_ser, bit_st, tx_pin, rx_pin;
  logic [1:0] rx_ser, irda, send_zero;
  logic [1:0][7:0] qcr, lfr, mlcr, in_d, out_d, level;
  logic [31:0] seed = 32'd43750;
  logic [7:0] q[2][$];
  int errors, num_checks, cycles, n;
  ufd_top u_ufd_top (.clk(clk), .rst_n(rst_n), .fifo_depth_strap(strap),
    .strap_level(strap_level), .queue_control_wr(qc_wr), .queue_control_reg(qcr),
    .line_format_reg(lfr), .modem_line_control_reg(mlcr), .enhanced_mode(enh),
    .depth_is_128(depth), .tx_in_valid(in_v), .tx_in_ready(in_r), .tx_in_data(in_d),
    .tx_out_valid(out_v), .tx_out_ready(out_r), .tx_out_data(out_d), .tx_level(level),
    .baud16_tick(tick), .tx_serial(tx_ser), .tx_bit_start(bit_st), .serial_tx_pin(tx_pin),
    .serial_rx_pin(rx_pin), .rx_serial(rx_ser), .func0_irq(f0), .func1_irq(f1),
    .func1_to_secondary(route), .mini_pci_mode(mini), .clkrun_request(clkrun),
    .primary_irq_line_o(p_o), .primary_irq_line_oe(p_oe), .secondary_irq_line_o(s_o),
    .secondary_irq_line_oe(s_oe), .secondary_irq_line_i(s_oe ? 1'b0 : host_val));
  ufd_peer u_ufd_peer (.clk(clk), .rst_n(rst_n), .irda(irda), .send_zero(send_zero),
    .serial_rx_pin(rx_pin));
  // free-running clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      errors++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // queue control write on channel 0, answer settles two edges later
  task automatic wrq(input logic [7:0] v);
    qcr[0] = v;
    qc_wr[0] = 1'b1;
    tk(1);
    qc_wr[0] = 1'b0;
    tk(2);
  endtask
  // fill with the drain side stalled until ready drops; count is the cap
  task automatic fill(input int ch, input int cap);
    logic [31:0] r;
    n = 0;
    while (in_r[ch] === 1'b1 && n < 200)
    begin
      r = xs();
      in_v[ch] = 1'b1;
      in_d[ch] = r[7:0];
      q[ch].push_back(r[7:0]);
      tk(1);
      n++;
    end
    in_v[ch] = 1'b0;
    chk(n, cap);
    chk(level[ch], cap);
  endtask
  // drain with random stalls, each word taken compared to the model queue
  task automatic drain(input int ch);
    logic [31:0] r;
    logic v;
    logic [7:0] d;
    n = 0;
    while (q[ch].size() > 0 && n < 3000)
    begin
      r = xs();
      v = out_v[ch];
      d = out_d[ch];
      out_r[ch] = r[0];
      tk(1);
      if (r[0] && v === 1'b1)
        chk(d, q[ch].pop_front());
      n++;
    end
    out_r[ch] = 1'b0;
    chk(level[ch], 0);
  endtask
  // main sequence
  initial
  begin
    logic [31:0] r;
    // baud tick held high so every cycle is one sixteenth of a bit
    {rst_n, strap, tick, f0, f1, route, mini, clkrun, host_val} = 9'h045;
    {qc_wr, enh, in_v, out_r, bit_st, irda, send_zero} = '0;
    {qcr, lfr, mlcr, in_d} = '0;
    tx_ser = 2'b11;
    tk(10);
    rst_n = 1'b1;
    tk(4);
    chk(depth, 0);
    strap = 1'b1;
    tk(2);
    chk(strap_level, 1);
    tk(1);
    chk(depth, 3);
    strap = 1'b0;
    tk(3);
    chk({strap_level, depth}, 0);
    wrq(8'h20);
    chk(depth, 0);
    lfr[0] = 8'h80;
    wrq(8'h20);
    chk(depth, 1);
    wrq(8'h00);
    chk(depth, 0);
    fill(0, 16);
    drain(0);
    enh[1] = 1'b1;
    tk(1);
    chk(depth, 2);
    fill(1, 128);
    drain(1);
    enh[0] = 1'b1;
    mlcr[0] = 8'h40;
    irda = 2'b01;
    tk(2);
    chk(tx_pin[0], 0);
    tx_ser[0] = 1'b0;
    bit_st[0] = 1'b1;
    tk(1);
    bit_st[0] = 1'b0;
    n = 0;
    repeat (20)
    begin
      n += int'(tx_pin[0]);
      tk(1);
    end
    chk(n, 3);
    tx_ser[0] = 1'b1;
    send_zero[0] = 1'b1;
    tk(1);
    send_zero[0] = 1'b0;
    tk(3);
    chk(rx_ser[0], 0);
    tk(25);
    chk(rx_ser[0], 1);
    mlcr[0] = 8'h00;
    irda = 2'b00;
    tx_ser[0] = 1'b0;
    send_zero[0] = 1'b1;
    tk(3);
    chk({tx_pin[0], rx_ser[0]}, 0);
    send_zero[0] = 1'b0;
    tx_ser[0] = 1'b1;
    // random irq vectors; the shared pin idles released between them
    repeat (32)
    begin
      r = xs();
      {f0, f1, route, mini, clkrun, host_val} = r[5:0];
      tk(1);
      chk({p_oe, p_o}, {f0 | (f1 & (mini | ~route)), 1'b0});
      chk({s_oe, s_o}, {mini ? clkrun & host_val : f1 & route, 1'b0});
      {f0, f1, clkrun, host_val} = 4'h1;
      tk(2);
    end
    finish_test();
  end
endmodule
`default_nettype wire
